// ==== rtl/icx_ctrl.sv ====
/*
 two level, twelve source vectored interrupt controller.
 assumes: pins asynchronous, peripheral and core signals on clk,
 register port with read data one cycle after the read strobe.
*/
// The implementer's own choices: the register addresses and strobed register access.
// Operation
// - trig_type_a/b pick falling edge or low level for pins a and b.
// - edge mode samples pins each machine cycle, high then low sets flag.
// - edge mode pin a/b flags clear on the hardware call.
// - level mode flag follows pin, not cleared on entry, re-requests.
// - pins c-f edge only; hardware clears only when hw_clear_sel set.
// - timer a/b overflow flags clear when their call is made.
// - timer c request is ovf or ext flag, software clears both.
// - watchdog flag at bit 3, enabled by bit 4, software clears.
// - serial requests are rx or tx done, software clears only.
// - software may write every flag and so raise a request.
// - per source enables plus a global enable gate all requests.
// - per source priority; high service never preempted by low.
// - fixed order within a level, pin a first, watchdog last.
// - flags polled and resolved each machine cycle.
// - call only when free, last cycle, no return or enable write.
// - refused requests are not remembered.
// - call pushes program counter only, then loads the vector.
// - each source has its fixed vector address.
// - interrupt return ends service; plain return does not.
// - pins and timer a/b flags update at phase three.
// - the call lasts four machine cycles.
// - each source owns flag, enable, priority and vector.
module icx_ctrl
	import icx_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rd_data,
	// external request pins
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic ext_irq_pin_c,
	input wire logic ext_irq_pin_d,
	input wire logic ext_irq_pin_e,
	input wire logic ext_irq_pin_f,
	// peripheral event pulses
	input wire logic tmr_a_ovf,
	input wire logic tmr_b_ovf,
	input wire logic tmr_c_ovf,
	input wire logic tmr_c_ext,
	input wire logic rx_done,
	input wire logic tx_done,
	input wire logic rx_done_b,
	input wire logic tx_done_b,
	input wire logic wdog_timeout,
	// core
	input wire logic instr_last,
	input wire logic instr_is_exit,
	input wire logic isr_exit_instr,
	output logic long_call_start,
	output logic [15:0] long_call_vector,
	output logic long_call_busy
);
	import icx_pkg::*;

	typedef struct packed {
		logic [1:0] phase;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [5:0] samp;
		logic trig_a;
		logic trig_b;
		logic [NFLAG-1:0] flag;
		logic [1:0] tovf_pend;
		logic [3:0] hcs;
		logic [6:0] en;
		logic glb;
		logic [4:0] xen;
		logic [6:0] pri;
		logic [4:0] xpri;
		logic blk;
		logic ins_hi;
		logic ins_lo;
		icx_fsm_type st;
		logic [3:0] cnt;
		logic [7:0] rd_data;
		logic call;
		logic [15:0] vec;
		logic busy;
	} icx_state_type;

	icx_state_type q, d;

	// lowest set index wins, found bit on top
	function automatic logic [4:0] icx_pick(input logic [11:0] r);
		logic [4:0] res;
		res = 5'h00;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (r[i]) res = {1'b1, 4'(i)};
		end
		return res;
	endfunction

	function automatic logic [15:0] icx_vec(input logic [3:0] s);
		case (s)
			4'h0: icx_vec = 16'h0003;
			4'h1: icx_vec = 16'h000b;
			4'h2: icx_vec = 16'h0013;
			4'h3: icx_vec = 16'h001b;
			4'h4: icx_vec = 16'h0023;
			4'h5: icx_vec = 16'h002b;
			4'h6: icx_vec = 16'h003b;
			4'h7: icx_vec = 16'h0043;
			4'h8: icx_vec = 16'h004b;
			4'h9: icx_vec = 16'h0053;
			4'ha: icx_vec = 16'h005b;
			default: icx_vec = 16'h0063;
		endcase
	endfunction

	logic [NSRC-1:0] src;
	logic [NSRC-1:0] ena;
	logic [NSRC-1:0] hip;
	logic [4:0] win_hi;
	logic [4:0] win_lo;
	logic [NFLAG-1:0] wm;
	logic [NFLAG-1:0] wv;
	logic [NFLAG-1:0] clr;
	logic [NFLAG-1:0] set;
	logic [3:0] win;
	logic go;
	logic wr_gate;

	always_comb begin
		d = q;
		wm = '0;
		wv = '0;
		clr = '0;
		set = '0;
		win = 4'h0;
		go = 1'b0;
		wr_gate = 1'b0;
		d.call = 1'b0;
		d.rd_data = RST_BYTE;
		d.phase = q.phase + 2'h1;
		// second flop alone reads the first
		d.sync1 = {ext_irq_pin_f, ext_irq_pin_e, ext_irq_pin_d,
			ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};
		d.sync2 = q.sync1;
		// software writes, flags included
		if (reg_wr) begin
			case (reg_addr)
				OFF_TCTRL: begin
					d.trig_a = reg_wr_data[B_TRIG_A];
					d.trig_b = reg_wr_data[B_TRIG_B];
					wm[F_A] = 1'b1;
					wv[F_A] = reg_wr_data[B_FLAG_A];
					wm[F_B] = 1'b1;
					wv[F_B] = reg_wr_data[B_FLAG_B];
					wm[F_TA] = 1'b1;
					wv[F_TA] = reg_wr_data[B_TOVF_A];
					wm[F_TB] = 1'b1;
					wv[F_TB] = reg_wr_data[B_TOVF_B];
				end
				OFF_XFLAG: begin
					wm[F_C+:4] = 4'hf;
					wv[F_C+:4] = reg_wr_data[7:4];
				end
				OFF_HCSEL: d.hcs = reg_wr_data[7:4];
				OFF_EN: begin
					d.en = reg_wr_data[6:0];
					d.glb = reg_wr_data[B_GLOBAL];
					wr_gate = 1'b1;
				end
				OFF_XEN: begin
					d.xen = reg_wr_data[4:0];
					wr_gate = 1'b1;
				end
				OFF_PRI: begin
					d.pri = reg_wr_data[6:0];
					wr_gate = 1'b1;
				end
				OFF_XPRI: begin
					d.xpri = reg_wr_data[4:0];
					wr_gate = 1'b1;
				end
				OFF_WDOG: begin
					wm[F_WD] = 1'b1;
					wv[F_WD] = reg_wr_data[B_WDFLAG];
				end
				OFF_SER: begin
					wm[F_RX+:4] = 4'hf;
					wv[F_RX+:4] = reg_wr_data[3:0];
					wm[F_TCO+:2] = 2'h3;
					wv[F_TCO+:2] = reg_wr_data[5:4];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFF_TCTRL: d.rd_data = {q.flag[F_TB], 1'b0,
					q.flag[F_TA], 1'b0, q.flag[F_B], q.trig_b,
					q.flag[F_A], q.trig_a};
				OFF_XFLAG: d.rd_data = {q.flag[F_C+:4], 4'h0};
				OFF_HCSEL: d.rd_data = {q.hcs, 4'h0};
				OFF_EN: d.rd_data = {q.glb, q.en};
				OFF_XEN: d.rd_data = {3'h0, q.xen};
				OFF_PRI: d.rd_data = {1'b0, q.pri};
				OFF_XPRI: d.rd_data = {3'h0, q.xpri};
				OFF_WDOG: d.rd_data = {4'h0, q.flag[F_WD], 3'h0};
				OFF_SER: d.rd_data = {2'h0, q.flag[F_TCO+:2],
					q.flag[F_RX+:4]};
				OFF_STAT: d.rd_data = {5'h00, q.busy, q.ins_hi,
					q.ins_lo};
				default: d.rd_data = RST_BYTE;
			endcase
		end
		// event capture, timer a/b held for phase three
		d.tovf_pend = q.tovf_pend | {tmr_b_ovf, tmr_a_ovf};
		set[F_TCO] = tmr_c_ovf;
		set[F_TCE] = tmr_c_ext;
		set[F_RX] = rx_done;
		set[F_RX+1] = tx_done;
		set[F_RXB] = rx_done_b;
		set[F_RXB+1] = tx_done_b;
		set[F_WD] = wdog_timeout;
		if (q.phase == PH_SAMPLE) begin
			d.samp = q.sync2;
			set[F_TA] = d.tovf_pend[0];
			set[F_TB] = d.tovf_pend[1];
			d.tovf_pend = 2'h0;
			set[F_A] = q.trig_a & q.samp[0] & ~q.sync2[0];
			set[F_B] = q.trig_b & q.samp[1] & ~q.sync2[1];
			set[F_C+:4] = q.samp[5:2] & ~q.sync2[5:2];
		end
		// requests in fixed order
		src = {q.flag[F_WD], q.flag[F_C+:4],
			q.flag[F_RXB] | q.flag[F_RXB+1],
			q.flag[F_TCO] | q.flag[F_TCE],
			q.flag[F_RX] | q.flag[F_RX+1],
			q.flag[F_TB], q.flag[F_B], q.flag[F_TA], q.flag[F_A]};
		ena = {q.xen, q.en} & {NSRC{q.glb}};
		hip = {q.xpri, q.pri};
		win_hi = icx_pick(src & ena & hip);
		win_lo = icx_pick(src & ena & ~hip);
		d.blk = q.blk | wr_gate;
		if (isr_exit_instr) begin
			if (q.ins_hi) d.ins_hi = 1'b0;
			else d.ins_lo = 1'b0;
		end
		case (q.st)
			ICX_IDLE: begin
				if (q.phase == PH_POLL) begin
					// fresh poll each machine cycle, nothing kept
					d.blk = 1'b0;
					if (instr_last && !instr_is_exit && !q.blk &&
						!wr_gate && !q.ins_hi) begin
						if (win_hi[4]) begin
							go = 1'b1;
							win = win_hi[3:0];
							d.ins_hi = 1'b1;
						end else if (win_lo[4] && !q.ins_lo) begin
							go = 1'b1;
							win = win_lo[3:0];
							d.ins_lo = 1'b1;
						end
					end
				end
				if (go) begin
					d.st = ICX_CALL;
					d.cnt = CALL_LAST;
					d.call = 1'b1;
					d.busy = 1'b1;
					d.vec = icx_vec(win);
					case (win)
						S_PIN_A: clr[F_A] = q.trig_a;
						S_TMR_A: clr[F_TA] = 1'b1;
						S_PIN_B: clr[F_B] = q.trig_b;
						S_TMR_B: clr[F_TB] = 1'b1;
						4'h7, 4'h8, 4'h9, 4'ha:
							clr[F_C + int'(win - S_PIN_C)] =
								q.hcs[2'(win - S_PIN_C)];
						default: ;
					endcase
				end
			end
			ICX_CALL: begin
				d.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h0) begin
					d.st = ICX_IDLE;
					d.busy = 1'b0;
				end
			end
			default: d.st = ICX_IDLE;
		endcase
		// hardware set wins over any clear in the same cycle
		d.flag = ((q.flag & ~wm) | (wv & wm)) & ~clr | set;
		if (q.phase == PH_SAMPLE) begin
			// level mode: flag mirrors a low pin, re-requests
			if (!q.trig_a) d.flag[F_A] = ~q.sync2[0];
			if (!q.trig_b) d.flag[F_B] = ~q.sync2[1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) q <= '0;
		else q <= d;
	end

	assign reg_rd_data = q.rd_data;
	assign long_call_start = q.call;
	assign long_call_vector = q.vec;
	assign long_call_busy = q.busy;

	default clocking icx_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	poll_phase_a: assert property (q.call |->
		$past(q.phase) == PH_POLL)
		else $error("call outside poll phase");
	global_gate_a: assert property (q.call |-> $past(q.glb))
		else $error("call with global enable off");
	cond_check_a: assert property (q.call |->
		$past(instr_last) && !$past(instr_is_exit))
		else $error("call outside last cycle or on return");
	call_len_a: assert property ($rose(q.busy) |->
		##15 q.busy ##1 !q.busy)
		else $error("call not four machine cycles");
	no_preempt_a: assert property (q.call |->
		!$past(q.ins_hi))
		else $error("high service preempted");
	tmr_clear_a: assert property (q.call &&
		q.vec == 16'h000b |-> !q.flag[F_TA])
		else $error("timer a flag kept on entry");
	pin_a_clear_a: assert property (q.call &&
		q.vec == 16'h0003 && q.trig_a |-> !q.flag[F_A])
		else $error("edge flag a kept on entry");
	tmr_c_keep_a: assert property (q.call &&
		q.vec == 16'h002b |-> q.flag[F_TCO] | q.flag[F_TCE])
		else $error("timer c flag cleared by call");
	wdog_keep_a: assert property (q.call &&
		q.vec == 16'h0063 |-> q.flag[F_WD])
		else $error("watchdog flag cleared by call");
	ser_keep_a: assert property (q.call &&
		q.vec == 16'h0023 |-> q.flag[F_RX] | q.flag[F_RX+1])
		else $error("serial flag cleared by call");
	edge_set_a: assert property (q.phase == PH_SAMPLE &&
		q.trig_a && q.samp[0] && !q.sync2[0] |=> q.flag[F_A])
		else $error("falling edge on pin a missed");
	level_track_a: assert property (q.phase == PH_SAMPLE &&
		!q.trig_a |=> q.flag[F_A] == !$past(q.sync2[0]))
		else $error("level flag does not follow pin a");
	exit_clear_a: assert property (isr_exit_instr &&
		q.ins_hi |=> !q.ins_hi)
		else $error("return left high marker set");

	hi_call_c: cover property (q.call && q.ins_hi && q.ins_lo);
	lo_call_c: cover property (q.call && !q.ins_hi);
	exit_c: cover property (isr_exit_instr && q.ins_lo);
	tie_c: cover property (q.call && q.vec == 16'h0013);
endmodule

// ==== rtl/icx_pkg.sv ====
/*
 package of the two level vectored interrupt controller: register
 offsets, field positions, flag slots, source numbers and cycle counts.
 assumes a four clock machine cycle derived from clk.
*/
package icx_pkg;
	// register offsets
	localparam logic [3:0] OFF_TCTRL = 4'h0;
	localparam logic [3:0] OFF_XFLAG = 4'h1;
	localparam logic [3:0] OFF_HCSEL = 4'h2;
	localparam logic [3:0] OFF_EN = 4'h3;
	localparam logic [3:0] OFF_XEN = 4'h4;
	localparam logic [3:0] OFF_PRI = 4'h5;
	localparam logic [3:0] OFF_XPRI = 4'h6;
	localparam logic [3:0] OFF_WDOG = 4'h7;
	localparam logic [3:0] OFF_SER = 4'h8;
	localparam logic [3:0] OFF_STAT = 4'h9;
	// timer_ctrl_reg fields, then the global enable and watchdog flag bits
	localparam int B_TRIG_A = 0;
	localparam int B_FLAG_A = 1;
	localparam int B_TRIG_B = 2;
	localparam int B_FLAG_B = 3;
	localparam int B_TOVF_A = 5;
	localparam int B_TOVF_B = 7;
	localparam int B_GLOBAL = 7;
	localparam int B_WDFLAG = 3;
	// flag slots
	localparam int F_A = 0;
	localparam int F_B = 1;
	localparam int F_C = 2;
	localparam int F_TA = 6;
	localparam int F_TB = 7;
	localparam int F_TCO = 8;
	localparam int F_TCE = 9;
	localparam int F_RX = 10;
	localparam int F_RXB = 12;
	localparam int F_WD = 14;
	localparam int NFLAG = 15;
	localparam int NSRC = 12;
	// source numbers, highest first
	localparam logic [3:0] S_PIN_A = 4'h0;
	localparam logic [3:0] S_TMR_A = 4'h1;
	localparam logic [3:0] S_PIN_B = 4'h2;
	localparam logic [3:0] S_TMR_B = 4'h3;
	localparam logic [3:0] S_SER0 = 4'h4;
	localparam logic [3:0] S_TMR_C = 4'h5;
	localparam logic [3:0] S_PIN_C = 4'h7;
	localparam logic [3:0] S_WDOG = 4'hb;
	// machine cycle timing
	localparam int MC_CLKS = 4;
	localparam int CALL_MCS = 4;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [1:0] PH_POLL = 2'h0;
	localparam logic [3:0] CALL_LAST = 4'(CALL_MCS * MC_CLKS - 1);
	localparam logic [7:0] RST_BYTE = 8'h00;
	typedef enum logic [0:0] {
		ICX_IDLE = 1'b0,
		ICX_CALL = 1'b1
	} icx_fsm_type;
endpackage

// ==== tb/icx_core_model.sv ====
/*
 core side of the interrupt controller: ends each instruction at
 random, runs a service routine and leaves it with an interrupt return.
 assumes the controller's call outputs are registered on clk.
*/
module icx_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench control: stay in the routine, like a plain return
	input wire logic hold,
	// controller side
	input wire logic long_call_start,
	input wire logic long_call_busy,
	output logic instr_last,
	output logic instr_is_exit,
	output logic isr_exit_instr
);
	timeunit 1ns;
	timeprecision 1ns;
	int depth;
	int cnt;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			depth = 0;
			cnt = 0;
			instr_last <= 1'b0;
			instr_is_exit <= 1'b0;
			isr_exit_instr <= 1'b0;
		end else begin
			isr_exit_instr <= 1'b0;
			// long instructions now and then delay the poll
			instr_last <= ($urandom % 4) != 0;
			instr_is_exit <= depth > 0 && cnt > 0 && cnt < 4 && !hold;
			if (long_call_start) begin
				depth++;
				cnt = 20 + $urandom % 20;
			end else if (depth > 0 && !long_call_busy && !hold) begin
				if (cnt > 0) cnt--;
				if (cnt == 0) begin
					isr_exit_instr <= 1'b1;
					depth--;
					cnt = 24;
				end
			end
		end
	end
endmodule

// ==== tb/tb_icx_ctrl.sv ====
/*
 self-checking bench of the interrupt controller: register port
 tasks, order of service, gating, priority, pin edge and level modes.
 assumes the core model in icx_core_model and seed 51303.
*/
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_icx_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, reg_wr, reg_rd, hold;
	logic [3:0] reg_addr;
	logic [7:0] reg_wr_data, reg_rd_data, d;
	logic [5:0] pins;
	logic [8:0] ev, r;
	logic [3:0] hc;
	logic instr_last, instr_is_exit, isr_exit_instr;
	logic long_call_start, long_call_busy, hw, q;
	logic [15:0] long_call_vector;
	logic [7:0] sh [16];
	int num_errors, checks_done, i, n;
	logic [15:0] vecs [12] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
		16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053,
		16'h005b, 16'h0063};
	logic [3:0] offs [12] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h8,
		4'h1, 4'h1, 4'h1, 4'h1, 4'h7};
	logic [7:0] msks [12] = '{8'h02, 8'h20, 8'h08, 8'h80, 8'h03, 8'h30,
		8'h0c, 8'h10, 8'h20, 8'h40, 8'h80, 8'h08};
	icx_ctrl u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rd_data(reg_rd_data), .ext_irq_pin_a(pins[0]),
		.ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]),
		.ext_irq_pin_d(pins[3]), .ext_irq_pin_e(pins[4]),
		.ext_irq_pin_f(pins[5]), .tmr_a_ovf(ev[0]), .tmr_b_ovf(ev[1]),
		.tmr_c_ovf(ev[2]), .tmr_c_ext(ev[3]), .rx_done(ev[4]),
		.tx_done(ev[5]), .rx_done_b(ev[6]), .tx_done_b(ev[7]),
		.wdog_timeout(ev[8]), .instr_last(instr_last),
		.instr_is_exit(instr_is_exit), .isr_exit_instr(isr_exit_instr),
		.long_call_start(long_call_start),
		.long_call_vector(long_call_vector),
		.long_call_busy(long_call_busy));
	icx_core_model u_core (.clk(clk), .rst(rst), .hold(hold),
		.long_call_start(long_call_start), .long_call_busy(long_call_busy),
		.instr_last(instr_last), .instr_is_exit(instr_is_exit),
		.isr_exit_instr(isr_exit_instr));
	always #5 clk = ~clk;
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rd_data;
	endtask
	// bounded wait; a missing call counts as one mismatch
	task automatic wait_call();
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (long_call_start !== 1'b1 && n < 300);
		`CHK("call", 1'b1, long_call_start)
	endtask
	task automatic quiet(output logic ok);
		ok = 1'b1;
		repeat (40) begin
			@(posedge clk);
			#1 if (long_call_start !== 1'b0) ok = 1'b0;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		num_errors++;
		end_of_test();
	end
	initial begin
		clk = 0; rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0;
		reg_wr_data = 0; pins = 6'h3f; ev = 0; hold = 0;
		num_errors = 0; checks_done = 0;
		foreach (sh[k]) sh[k] = 8'h00;
		void'($urandom(51303));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 16; i++) begin
			rd(4'(i), d);
			`CHK("reset", 8'h00, d);
		end
		$display("test reset done");
		sh[0] = 8'h05;
		wr(4'h0, sh[0]);
		repeat (3) begin
			r = 9'($urandom);
			@(posedge clk);
			ev <= r;
			@(posedge clk);
			ev <= 9'h000;
			repeat (8) @(posedge clk);
			rd(4'h0, d);
			`CHK("tctrl", sh[0] | {r[1], 1'b0, r[0], 5'h00}, d);
			rd(4'h8, d);
			`CHK("serial", {2'b00, r[3], r[2], r[7:4]}, d);
			rd(4'h7, d);
			`CHK("wdog", {4'h0, r[8], 3'h0}, d);
			wr(4'h0, sh[0]);
			wr(4'h8, 8'h00);
			wr(4'h7, 8'h00);
		end
		$display("test events done");
		// flags set by software, all at one level, served in fixed order
		hc = 4'($urandom);
		wr(4'h2, {hc, 4'h0});
		sh[0] = 8'haf; sh[1] = 8'hf0; sh[8] = 8'h3f; sh[7] = 8'h08;
		wr(4'h0, sh[0]);
		wr(4'h1, sh[1]);
		wr(4'h8, sh[8]);
		wr(4'h7, sh[7]);
		wr(4'h3, 8'hff);
		wr(4'h4, 8'h1f);
		for (i = 0; i < 12; i++) begin
			wait_call();
			`CHK("vector", vecs[i], long_call_vector);
			hw = (i < 4) || (i >= 7 && i < 11 && hc[(i - 7) & 3]);
			rd(offs[i], d);
			`CHK("flag", hw ? sh[offs[i]] & ~msks[i] : sh[offs[i]], d);
			sh[offs[i]] &= ~msks[i];
			wr(offs[i], sh[offs[i]]);
		end
		$display("test order done");
		wr(4'h3, 8'h7f);
		wr(4'h6, 8'h10);
		hold <= 1'b1;
		sh[0] = 8'h07;
		wr(4'h0, sh[0]);
		wr(4'h7, 8'h08);
		quiet(q);
		`CHK("gated", 1'b1, q);
		wr(4'h3, 8'hff);
		wait_call();
		`CHK("vector", 16'h0063, long_call_vector);
		quiet(q);
		`CHK("preempt", 1'b1, q);
		rd(4'h9, d);
		`CHK("status", 8'h03, d);
		wr(4'h7, 8'h00);
		hold <= 1'b0;
		wait_call();
		`CHK("vector", 16'h0003, long_call_vector);
		$display("test priority done");
		@(posedge clk);
		pins[0] <= 1'b0;
		wait_call();
		`CHK("vector", 16'h0003, long_call_vector);
		n = 0;
		while (long_call_busy === 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK("busy", 16, n);
		@(posedge clk);
		pins[0] <= 1'b1;
		$display("test edge done");
		sh[0] = 8'h01;
		wr(4'h0, sh[0]);
		@(posedge clk);
		pins[1] <= 1'b0;
		wait_call();
		`CHK("vector", 16'h0013, long_call_vector);
		rd(4'h0, d);
		`CHK("level", 8'h09, d);
		wait_call();
		`CHK("vector", 16'h0013, long_call_vector);
		@(posedge clk);
		pins[1] <= 1'b1;
		$display("test level done");
		end_of_test();
	end
endmodule
